//--- verilog/ism_slave.sv
// Purpose: Slave engine of a two-wire serial port with address masking and clock stretching
// Assumes: Software strobes are one-cycle pulses on REF_CLK
// Notes:   Wire levels pass a three-flop filter before edges are found
// Summary of operation
// - 7-bit mask bits make address bits don't-care
// - 10-bit mask bit one covers two LSBs
// - 10-bit upper address bits compared exactly
// - Acknowledge when all unmasked bits match
// - Write match clears direction, loads buffer, acks
// - Full buffer or overflow withholds address ack
// - Flag every byte but unmatched addresses; software clears flag
// - Stretch enable holds clock after received data bytes
// - Read match sets direction, loads, acks, stretches
// - Buffer write loads shift register too
// - Transmit bits change on falling clock edges
// - Latch master ack on ninth rise
// - Transmit flag set on ninth falling edge
// - Receive stretch at ninth fall if full
// - Software may set release bit anytime
// - Update-address flag stretches without clearing release
// - Update-address set after high and low bytes
// - Full-buffer stretch only in data phases
// - Transmit stretch at ninth fall if empty
// - Third 10-bit phase then transmit stretching
// - Drive clock low only once sampled low
// - Hold clock until release bit set
// - Compare address on eighth falling edge
// - Master sends 11110, A9, A8, write bit
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
module ism_slave
	import ism_pkg::*;
(
	input  wire logic       REF_CLK,
	input  wire logic       RST_N,
	ism_link_if.dev         LINK,
	input  wire logic [7:0] ADDR_WDATA,
	input  wire logic       ADDR_WE,
	input  wire logic [4:0] ADDR_MASK_BITS,
	input  wire logic       TEN_BIT,
	input  wire logic       STRETCH_ENABLE,
	input  wire logic [7:0] BUF_WDATA,
	input  wire logic       BUF_WE,
	input  wire logic       BUF_RE,
	input  wire logic       CLOCK_RELEASE_SET,
	input  wire logic       OVERFLOW_CLR,
	input  wire logic       IRQ_CLR,
	output logic      [7:0] DATA_BUFFER,
	output logic            BUFFER_FULL,
	output logic            RECEIVE_OVERFLOW,
	output logic            PORT_IRQ_FLAG,
	output logic            DIR_READ,
	output logic            UPDATE_ADDRESS,
	output logic            CLOCK_RELEASE
);
	logic [2:0]    scl_sync;	// Clock pin synchroniser
	logic [2:0]    sda_sync;	// Data pin synchroniser
	logic          scl_f;	// Filtered clock level
	logic          sda_f;	// Filtered data level
	logic          scl_prev;	// Clock level one cycle ago
	logic          sda_prev;	// Data level one cycle ago
	logic          scl_rise;	// Clock rising edge
	logic          scl_fall;	// Clock falling edge
	logic          start_cond;	// Start or repeated start seen
	logic          stop_cond;	// Stop seen
	logic          fall8;	// Falling edge ending the eighth bit
	logic          fall9;	// Falling edge ending the ninth bit
	logic [3:0]    bitcnt;	// Rising edges in this byte
	logic [7:0]    shift_register;	// Receive and transmit shifter
	logic [7:0]    slave_address_reg;	// Stored own address
	ism_phase_type phase;	// Current transfer phase
	ism_phase_type pend_phase;	// Phase after the ninth bit
	logic          ten_stage;	// Low address byte expected
	logic          matched10;	// Full 10-bit address matched
	logic          mnack;	// Master answered not-acknowledge
	logic          irq_pend;	// Byte raises flag at ninth fall
	logic          ua_hold;	// Stretch held by update-address
	logic          hit;	// Address byte matches
	logic          ack_now;	// Acknowledge this byte
	logic          clr_rel;	// Hardware clears release bit
	logic          buf_take;	// Software buffer write accepted

	// Masked compare of seven bits, mask on bits 5..1
	function automatic logic match7(input logic [6:0] rx, input logic [6:0] own, input logic [4:0] m);
		return ((rx ^ own) & ~{2'b00, m}) == 7'h00;
	endfunction

	// Masked compare of the low 10-bit address byte
	function automatic logic match10lo(input logic [7:0] rx, input logic [7:0] own, input logic [4:0] m);
		return ((rx ^ own) & ~{2'b00, m[4:1], m[0], m[0]}) == 8'h00;
	endfunction

	// Three-flop filter on both wires
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			scl_f    <= 1'b1;
			sda_f    <= 1'b1;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[1:0], LINK.scl};
			sda_sync <= {sda_sync[1:0], LINK.sda};
			if (scl_sync[2] == scl_sync[1]) begin
				scl_f <= scl_sync[2];
			end
			if (sda_sync[2] == sda_sync[1]) begin
				sda_f <= sda_sync[2];
			end
			scl_prev <= scl_f;
			sda_prev <= sda_f;
		end
	end

	// Edge and condition detection
	assign scl_rise   = scl_f & ~scl_prev;
	assign scl_fall   = ~scl_f & scl_prev;
	assign start_cond = scl_f & scl_prev & sda_prev & ~sda_f;
	assign stop_cond  = scl_f & scl_prev & ~sda_prev & sda_f;
	assign fall8      = scl_fall && (bitcnt == BIT_LAST_DATA) && (phase != PH_IDLE);
	assign fall9      = scl_fall && (bitcnt == BIT_ACK) && (phase != PH_IDLE);
	assign buf_take   = BUF_WE && (phase == PH_TX) && ((bitcnt == 4'h0) || (bitcnt == BIT_ACK));

	// Address match and acknowledge decision
	always_comb begin
		hit = 1'b0;
		if (!TEN_BIT) begin
			hit = match7(shift_register[7:1], slave_address_reg[7:1], ADDR_MASK_BITS);
		end else if (!ten_stage) begin
			hit = (shift_register[7:3] == TEN_BIT_PREFIX) && (shift_register[7:1] == slave_address_reg[7:1])
				&& (!shift_register[0] || matched10);
		end else begin
			hit = match10lo(shift_register, slave_address_reg, ADDR_MASK_BITS);
		end
		case (phase)
			PH_ADDR: ack_now = hit && !BUFFER_FULL && !RECEIVE_OVERFLOW;
			PH_RX:   ack_now = !BUFFER_FULL && !RECEIVE_OVERFLOW;
			default: ack_now = 1'b0;
		endcase
	end

	// Bit counter
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bitcnt <= 4'h0;
		end else if (start_cond || stop_cond || fall9) begin
			bitcnt <= 4'h0;
		end else if (scl_rise && (phase != PH_IDLE) && (bitcnt < BIT_ACK)) begin
			bitcnt <= bitcnt + 4'h1;
		end
	end

	// Shift register
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			shift_register <= 8'h00;
		end else if (start_cond) begin
			shift_register <= 8'h00;
		end else if (buf_take) begin
			shift_register <= BUF_WDATA;
		end else if (phase == PH_TX) begin
			if (scl_fall && (bitcnt != 4'h0) && (bitcnt < BIT_LAST_DATA)) begin
				shift_register <= {shift_register[6:0], 1'b0};
			end
		end else if (scl_rise && (phase != PH_IDLE) && (bitcnt < BIT_LAST_DATA)) begin
			shift_register <= {shift_register[6:0], sda_f};
		end
	end

	// Phase sequencing
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			phase      <= PH_IDLE;
			pend_phase <= PH_IDLE;
			ten_stage  <= 1'b0;
			matched10  <= 1'b0;
			mnack      <= 1'b0;
			irq_pend   <= 1'b0;
		end else if (stop_cond) begin
			phase     <= PH_IDLE;
			matched10 <= 1'b0;
		end else if (start_cond) begin
			phase     <= PH_ADDR;
			ten_stage <= 1'b0;
		end else begin
			if (fall8) begin
				irq_pend <= (phase != PH_ADDR) || hit;
				if (phase == PH_RX) begin
					pend_phase <= PH_RX;
				end else if (phase == PH_ADDR) begin
					if (!ack_now) begin
						pend_phase <= PH_IDLE;
					end else if (!TEN_BIT) begin
						pend_phase <= shift_register[0] ? PH_TX : PH_RX;
					end else if (!ten_stage) begin
						pend_phase <= shift_register[0] ? PH_TX : PH_ADDR;
						ten_stage  <= ~shift_register[0];
					end else begin
						pend_phase <= PH_RX;
						matched10  <= 1'b1;
					end
				end
			end
			if (scl_rise && (bitcnt == BIT_LAST_DATA) && (phase == PH_TX)) begin
				mnack <= sda_f;
			end
			if (fall9) begin
				if (phase == PH_TX) begin
					phase <= mnack ? PH_IDLE : PH_TX;
				end else begin
					phase <= pend_phase;
				end
			end
		end
	end

	// Data line drive
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LINK.sda_s_oe <= 1'b0;
		end else if (start_cond || stop_cond) begin
			LINK.sda_s_oe <= 1'b0;
		end else if (buf_take && (bitcnt == 4'h0)) begin
			LINK.sda_s_oe <= ~BUF_WDATA[7];
		end else if (fall8) begin
			LINK.sda_s_oe <= ack_now;
		end else if (fall9) begin
			LINK.sda_s_oe <= (phase == PH_TX) ? (~mnack & ~shift_register[7]) :
				((pend_phase == PH_TX) & ~shift_register[7]);
		end else if ((phase == PH_TX) && scl_fall && (bitcnt != 4'h0) && (bitcnt < BIT_LAST_DATA)) begin
			LINK.sda_s_oe <= ~shift_register[6];
		end
	end

	// Status flags and buffers
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			DATA_BUFFER       <= 8'h00;
			slave_address_reg <= 8'h00;
			BUFFER_FULL       <= 1'b0;
			RECEIVE_OVERFLOW  <= 1'b0;
			PORT_IRQ_FLAG     <= 1'b0;
			DIR_READ          <= 1'b0;
			UPDATE_ADDRESS    <= 1'b0;
		end else begin
			if (ADDR_WE) begin
				slave_address_reg <= ADDR_WDATA;
			end
			if (fall8 && ack_now) begin
				DATA_BUFFER <= shift_register;
			end else if (buf_take) begin
				DATA_BUFFER <= BUF_WDATA;
			end
			// Set wins over clear
			if ((fall8 && ack_now) || buf_take) begin
				BUFFER_FULL <= 1'b1;
			end else if (BUF_RE || (fall8 && (phase == PH_TX))) begin
				BUFFER_FULL <= 1'b0;
			end
			if (fall8 && (phase == PH_RX) && BUFFER_FULL) begin
				RECEIVE_OVERFLOW <= 1'b1;
			end else if (OVERFLOW_CLR) begin
				RECEIVE_OVERFLOW <= 1'b0;
			end
			if (fall9 && irq_pend) begin
				PORT_IRQ_FLAG <= 1'b1;
			end else if (IRQ_CLR) begin
				PORT_IRQ_FLAG <= 1'b0;
			end
			if (fall8 && ack_now && (phase == PH_ADDR)) begin
				DIR_READ <= shift_register[0] && !(TEN_BIT && ten_stage);
			end else if (fall9 && (phase == PH_TX) && mnack) begin
				DIR_READ <= 1'b0;
			end
			if (fall8 && ack_now && (phase == PH_ADDR) && TEN_BIT && (ten_stage || !shift_register[0])) begin
				UPDATE_ADDRESS <= 1'b1;
			end else if (ADDR_WE) begin
				UPDATE_ADDRESS <= 1'b0;
			end
		end
	end

	// Hardware clears release at ninth fall
	// receive stretch when full
	assign clr_rel = fall9 && (((phase == PH_ADDR) && (pend_phase == PH_TX))
		|| ((phase == PH_RX) && STRETCH_ENABLE && BUFFER_FULL)
		|| ((phase == PH_TX) && !mnack && !BUFFER_FULL));

	// Clock release and stretching
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CLOCK_RELEASE <= 1'b1;
			ua_hold       <= 1'b0;
			LINK.scl_s_oe <= 1'b0;
		end else begin
			if (CLOCK_RELEASE_SET) begin
				CLOCK_RELEASE <= 1'b1;
			end else if (clr_rel) begin
				CLOCK_RELEASE <= 1'b0;
			end
			if (ADDR_WE) begin
				ua_hold <= 1'b0;
			end else if (fall9 && (phase == PH_ADDR) && TEN_BIT && UPDATE_ADDRESS) begin
				ua_hold <= 1'b1;
			end
			if (CLOCK_RELEASE && !ua_hold) begin
				LINK.scl_s_oe <= 1'b0;
			end else if (!scl_f) begin
				LINK.scl_s_oe <= 1'b1;
			end
		end
	end
endmodule

//--- verilog/ism_pkg.sv
// Purpose: Shared constants and types for the two-wire slave and its bus master
// Assumes: REF_CLK at 25 MHz on both ends
// Notes:   Offsets are byte addresses on the master's register bus
package ism_pkg;
	// Clock and serial timing
	localparam int          CLK_PERIOD_NS  = 40;
	localparam int          SCL_PERIOD_NS  = 640;
	localparam int          QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [2:0]  QUARTER_LAST   = 3'(QUARTER_CYCLES - 1);
	// Bit counts within one byte
	localparam logic [3:0]  BIT_LAST_DATA  = 4'h8;
	localparam logic [3:0]  BIT_ACK        = 4'h9;
	// First byte prefix of a 10-bit address
	localparam logic [4:0]  TEN_BIT_PREFIX = 5'h1E;
	// Master register map
	localparam logic [3:0]  REG_CMD        = 4'h0;
	localparam logic [3:0]  REG_STATUS     = 4'h4;
	localparam logic [3:0]  REG_RXDATA     = 4'h8;
	// Command word fields
	localparam int          CMD_START_BIT  = 8;
	localparam int          CMD_STOP_BIT   = 9;
	localparam int          CMD_READ_BIT   = 10;
	localparam int          CMD_NACK_BIT   = 11;
	// Status word fields
	localparam int          STAT_BUSY_BIT  = 0;
	localparam int          STAT_NACK_BIT  = 1;
	// Bus responses
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// Slave transfer phases
	typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_RX, PH_TX} ism_phase_type;
	// Master sequencer states
	typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} ism_mstate_type;
endpackage

//--- verilog/ism_link_if.sv
// Purpose: Open-drain clock and data wires shared by master and slave
// Assumes: External pull-ups, modelled as high when nobody drives
// Notes:   An enable high pulls the wire low
interface ism_link_if;
	logic scl_m_oe;	// Master pulls clock low
	logic sda_m_oe;	// Master pulls data low
	logic scl_s_oe;	// Slave pulls clock low
	logic sda_s_oe;	// Slave pulls data low
	logic scl;	// Resolved clock level
	logic sda;	// Resolved data level
	// Wired-AND resolution
	assign scl = ~(scl_m_oe | scl_s_oe);
	assign sda = ~(sda_m_oe | sda_s_oe);
	modport dev (input scl, input sda, output scl_s_oe, output sda_s_oe);
	modport host (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface

//--- verilog/ism_master.sv
// Purpose: Two-wire bus master driven by commands over AXI4-Lite
// Assumes: Software composes address bytes, including the 10-bit prefix byte
// Notes:   Waits while the slave stretches the clock
module ism_master
	import ism_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	ism_link_if.host         LINK,
	input  wire logic [3:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic      [1:0]  S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [3:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic      [31:0] S_AXI_RDATA,
	output logic      [1:0]  S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY
);
	logic [2:0]     scl_sync;	// Clock wire synchroniser
	logic [2:0]     sda_sync;	// Data wire synchroniser
	logic           scl_f;	// Filtered clock level
	logic           sda_f;	// Filtered data level
	logic [3:0]     aw_addr;	// Held write address
	logic [31:0]    w_data;	// Held write data
	logic [3:0]     w_strb;	// Held byte enables
	logic           wr_do;	// Both write halves held
	logic           cmd_go;	// Command accepted
	ism_mstate_type ms;	// Sequencer state
	logic [1:0]     q;	// Quarter within a bit
	logic [2:0]     tcnt;	// Cycles within a quarter
	logic           adv;	// Quarter ends
	logic [3:0]     bit_idx;	// Bit within byte
	logic [8:0]     tx_sh;	// Outgoing bits with ack slot
	logic [8:0]     rx_sh;	// Sampled bits with ack slot
	logic           c_stop;	// Stop after this byte
	logic           c_read;	// Byte is a read
	logic [7:0]     rx_data;	// Last byte received
	logic           nack_seen;	// Ack slot read high after last write byte, zero after a read

	// Wire filters
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			scl_f    <= 1'b1;
			sda_f    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[1:0], LINK.scl};
			sda_sync <= {sda_sync[1:0], LINK.sda};
			if (scl_sync[2] == scl_sync[1]) begin
				scl_f <= scl_sync[2];
			end
			if (sda_sync[2] == sda_sync[1]) begin
				sda_f <= sda_sync[2];
			end
		end
	end

	// Write channel handshakes and response
	assign wr_do  = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
	assign cmd_go = wr_do && (aw_addr == REG_CMD) && (w_strb[1:0] == 2'h3) && (ms == MS_IDLE);
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= RESP_OKAY;
			aw_addr       <= 4'h0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				S_AXI_AWREADY <= 1'b0;
				aw_addr       <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				S_AXI_WREADY <= 1'b0;
				w_data       <= S_AXI_WDATA;
				w_strb       <= S_AXI_WSTRB;
			end
			if (wr_do) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= ((aw_addr == REG_CMD) && (ms == MS_IDLE)) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID  <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
			end
		end
	end

	// Read channel
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b1;
			S_AXI_RRESP   <= RESP_OKAY;
			case (S_AXI_ARADDR)
				REG_STATUS: S_AXI_RDATA <= {30'h0, nack_seen, ms != MS_IDLE};
				REG_RXDATA: S_AXI_RDATA <= {24'h00_0000, rx_data};
				default: begin
					S_AXI_RDATA <= 32'h0000_0000;
					S_AXI_RRESP <= RESP_SLVERR;
				end
			endcase
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID  <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// Quarter timer, frozen while the clock is held low by the slave
	assign adv = (tcnt == QUARTER_LAST) && (ms != MS_IDLE);
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tcnt <= 3'h0;
		end else if ((ms == MS_IDLE) || adv) begin
			tcnt <= 3'h0;
		end else if ((q != 2'h2) || scl_f) begin
			tcnt <= tcnt + 3'h1;
		end
	end

	// Bit sequencer
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ms            <= MS_IDLE;
			q             <= 2'h0;
			bit_idx       <= 4'h0;
			tx_sh         <= 9'h1FF;
			rx_sh         <= 9'h000;
			c_stop        <= 1'b0;
			c_read        <= 1'b0;
			rx_data       <= 8'h00;
			nack_seen     <= 1'b0;
			LINK.scl_m_oe <= 1'b0;
			LINK.sda_m_oe <= 1'b0;
		end else if (cmd_go) begin
			ms      <= w_data[CMD_START_BIT] ? MS_START : MS_BIT;
			q       <= 2'h0;
			bit_idx <= 4'h0;
			c_stop  <= w_data[CMD_STOP_BIT];
			c_read  <= w_data[CMD_READ_BIT];
			tx_sh   <= w_data[CMD_READ_BIT] ? {8'hFF, w_data[CMD_NACK_BIT]} : {w_data[7:0], 1'b1};
		end else if (adv) begin
			q <= q + 2'h1;
			case (q)
				2'h0: begin
					// Data changes with the clock low
					LINK.sda_m_oe <= (ms == MS_BIT) ? ~tx_sh[8] : (ms == MS_STOP);
				end
				2'h1: begin
					LINK.scl_m_oe <= 1'b0;
				end
				2'h2: begin
					rx_sh <= {rx_sh[7:0], sda_f};
					if (ms == MS_START) begin
						LINK.sda_m_oe <= 1'b1;
					end else if (ms == MS_STOP) begin
						LINK.sda_m_oe <= 1'b0;
					end
				end
				default: begin
					if (ms == MS_STOP) begin
						ms <= MS_IDLE;
					end else begin
						LINK.scl_m_oe <= 1'b1;
						if (ms == MS_START) begin
							ms <= MS_BIT;
						end else begin
							tx_sh   <= {tx_sh[7:0], 1'b1};
							bit_idx <= bit_idx + 4'h1;
							if (bit_idx == BIT_LAST_DATA) begin
								ms        <= c_stop ? MS_STOP : MS_IDLE;
								rx_data   <= rx_sh[8:1];
								nack_seen <= c_read ? 1'b0 : rx_sh[0];
							end
						end
					end
				end
			endcase
		end
	end
endmodule

//--- sim/ism_link_sva.sv
// Purpose: Wire and flag checks beside the link
// Assumes: One REF_CLK domain, reset async low
// Notes:   Inputs are plain copies of link and slave signals
module ism_link_sva (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic scl_s_oe,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic CLOCK_RELEASE,
	input wire logic BUFFER_FULL,
	input wire logic RECEIVE_OVERFLOW,
	input wire logic PORT_IRQ_FLAG,
	input wire logic DIR_READ,
	input wire logic UPDATE_ADDRESS,
	input wire logic IRQ_CLR,
	input wire logic ADDR_WE
);
	timeunit 1ns;
	timeprecision 1ns;
	// Single domain
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	chk_stretch_late: assert property ($rose(scl_s_oe) |-> !$past(scl))
		else $error("clock pulled low while high");
	chk_hold_release: assert property ($fell(scl_s_oe) |-> $past(CLOCK_RELEASE))
		else $error("clock let go without release bit");
	chk_rx_stretch: assert property ($fell(CLOCK_RELEASE) && !$past(DIR_READ) |-> $past(BUFFER_FULL))
		else $error("receive stretch with empty buffer");
	chk_data_steady: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("data moved while clock high");
	chk_irq_clock_low: assert property ($rose(PORT_IRQ_FLAG) |-> !scl)
		else $error("flag raised while clock high");
	chk_ack_refused: assert property ($rose(sda_s_oe) && !DIR_READ |-> !$past(BUFFER_FULL || RECEIVE_OVERFLOW))
		else $error("ack given while full");
	chk_irq_kept: assert property ($fell(PORT_IRQ_FLAG) |-> $past(IRQ_CLR))
		else $error("flag dropped on its own");
	chk_ua_kept: assert property ($fell(UPDATE_ADDRESS) |-> $past(ADDR_WE))
		else $error("update flag dropped on its own");
	// Main scenarios
	cover property ($rose(scl_s_oe));
	cover property ($rose(UPDATE_ADDRESS));
	cover property ($rose(DIR_READ));
endmodule

//--- sim/i2c_slave_mask_stretch_tb.sv
// Purpose: Bench joining master and slave over the link
// Assumes: Master commands over AXI4-Lite, slave strobes direct
// Notes:   Strobe bits are buffer read, flag clear, overflow clear, release
module i2c_slave_mask_stretch_tb
	import ism_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk, rst_n = 1'b0;
	logic [7:0]  addr_wd = 8'h00, buf_wd = 8'h00, buf_q;
	logic        addr_we = 1'b0, buf_we = 1'b0, ten = 1'b0, se = 1'b0;
	logic [4:0]  mask = 5'h07;
	logic [3:0]  strb = 4'h0, awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic        awr, wrr, bv, arr, rv, bf, ovf, irq, dirr, ua, crel;
	logic [1:0]  rresp, lr, bresp, lb;
	logic [8:0]  t1 [4] = '{9'h1B0, 9'h120, 9'h0AE, 9'h0A6};
	int          n_errors = 0, n_checks = 0;
	ism_link_if  lk();
	ism_slave u_ism_slave (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(lk.dev), .ADDR_WDATA(addr_wd), .ADDR_WE(addr_we),
		.ADDR_MASK_BITS(mask), .TEN_BIT(ten), .STRETCH_ENABLE(se), .BUF_WDATA(buf_wd), .BUF_WE(buf_we),
		.BUF_RE(strb[3]), .IRQ_CLR(strb[2]), .OVERFLOW_CLR(strb[1]), .CLOCK_RELEASE_SET(strb[0]),
		.DATA_BUFFER(buf_q), .BUFFER_FULL(bf), .RECEIVE_OVERFLOW(ovf), .PORT_IRQ_FLAG(irq), .DIR_READ(dirr),
		.UPDATE_ADDRESS(ua), .CLOCK_RELEASE(crel));
	ism_master u_ism_master (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(lk.host), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rr));
	ism_link_sva u_ism_link_sva (.REF_CLK(ref_clk), .RST_N(rst_n), .scl_s_oe(lk.scl_s_oe), .sda_s_oe(lk.sda_s_oe),
		.scl(lk.scl), .CLOCK_RELEASE(crel), .BUFFER_FULL(bf), .RECEIVE_OVERFLOW(ovf), .PORT_IRQ_FLAG(irq),
		.DIR_READ(dirr), .UPDATE_ADDRESS(ua), .IRQ_CLR(strb[2]), .ADDR_WE(addr_we));
	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// Compare and count
	task ck(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// Bus write, both channels at once
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awr) awv <= 1'b0;
			if (wrr) wv <= 1'b0;
		end while (!bv);
		lb = bresp;
		br <= 1'b0;
	endtask
	// Bus read
	task rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		araddr <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		v = rdata;
		lr = rresp;
		rr <= 1'b0;
	endtask
	// One byte on the link, then ack check
	task tx(input logic [11:0] c, input logic n);
		logic [31:0] s;
		wr(REG_CMD, {20'h0, c});
		ck(lb, RESP_OKAY);
		s = 32'h1;
		while (s[STAT_BUSY_BIT]) rd(REG_STATUS, s);
		if (n !== 1'bx) ck(s[STAT_NACK_BIT], n);
	endtask
	// Software strobes
	task sw(input logic [3:0] m);
		@(posedge ref_clk);
		strb <= m;
		@(posedge ref_clk);
		strb <= 4'h0;
	endtask
	// Transmit byte load, then release
	task ld(input logic [7:0] v);
		@(posedge ref_clk);
		buf_wd <= v;
		buf_we <= 1'b1;
		@(posedge ref_clk);
		buf_we <= 1'b0;
		sw(4'h5);
	endtask
	// Own address write
	task sa(input logic [7:0] a);
		@(posedge ref_clk);
		addr_wd <= a;
		addr_we <= 1'b1;
		@(posedge ref_clk);
		addr_we <= 1'b0;
	endtask
	// Verdict
	task summarize();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		#1000000;
		n_errors++;
		summarize();
	end
	// Tests
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		sa(8'hA0);
		rd(4'hC, d);
		ck(lr, RESP_SLVERR);
		ck(d[7:0], 8'h00);
		wr(REG_STATUS, 32'h0);
		ck(lb, RESP_SLVERR);
		$display("test 0 done");
		for (int i = 0; i < 4; i++) begin
			tx({4'h3, t1[i][7:0]}, t1[i][8]);
			ck(bf, !t1[i][8]);
			ck(irq, !t1[i][8]);
			ck(buf_q, t1[i][8] ? 8'h00 : t1[i][7:0]);
			ck(dirr, 1'b0);
			sw(4'hC);
		end
		$display("test 1 done");
		tx(12'h3AE, 1'b0);
		tx(12'h3AE, 1'b1);
		sw(4'hC);
		tx(12'h1AE, 1'b0);
		tx(12'h011, 1'b1);
		ck(ovf, 1'b1);
		ck(buf_q, 8'hAE);
		sw(4'hC);
		tx(12'h3AE, 1'b1);
		sw(4'h6);
		$display("test 2 done");
		se <= 1'b1;
		tx(12'h1AE, 1'b0);
		repeat (8) @(posedge ref_clk);
		ck(crel, 1'b1);
		sw(4'hC);
		tx(12'h05A, 1'b0);
		repeat (8) @(posedge ref_clk);
		ck(crel, 1'b0);
		ck(lk.scl_s_oe, 1'b1);
		ck(buf_q, 8'h5A);
		sw(4'h1);
		repeat (2) @(posedge ref_clk);
		ck(crel, 1'b1);
		ck(lk.scl_s_oe, 1'b0);
		se <= 1'b0;
		sw(4'hC);
		tx(12'h2A5, 1'b0);
		sw(4'hC);
		$display("test 3 done");
		tx(12'h1A1, 1'b0);
		repeat (8) @(posedge ref_clk);
		ck(dirr, 1'b1);
		ck(crel, 1'b0);
		ck(buf_q, 8'hA1);
		ld(8'hC3);
		tx(12'h400, 1'bx);
		repeat (8) @(posedge ref_clk);
		rd(REG_RXDATA, d);
		ck(d[7:0], 8'hC3);
		ck(crel, 1'b0);
		ck(dirr, 1'b1);
		ld(8'h3C);
		tx(12'hE00, 1'bx);
		rd(REG_RXDATA, d);
		ck(d[7:0], 8'h3C);
		ck(dirr, 1'b0);
		ck(irq, 1'b1);
		sw(4'hC);
		$display("test 4 done");
		ten <= 1'b1;
		sa(8'hF2);
		tx(12'h1F2, 1'b0);
		repeat (8) @(posedge ref_clk);
		ck(ua, 1'b1);
		ck(crel, 1'b1);
		ck(lk.scl_s_oe, 1'b1);
		sw(4'hC);
		sa(8'hA0);
		repeat (2) @(posedge ref_clk);
		ck(lk.scl_s_oe, 1'b0);
		tx(12'h0AF, 1'b0);
		repeat (8) @(posedge ref_clk);
		ck(ua, 1'b1);
		ck(buf_q, 8'hAF);
		sw(4'hC);
		sa(8'hF2);
		tx(12'h233, 1'b0);
		sw(4'hC);
		mask <= 5'h1F;
		tx(12'h3F6, 1'b1);
		$display("test 5 done");
		summarize();
	end
endmodule
